// *** sdr_pkg.sv ***
package sdr_pkg;

  // ==========================================================================
  // Descriptor kinds (values arbitrary, not taken from any part)
  localparam logic [7:0] SDR_KIND_SECURITY = 8'h30;
  localparam logic [7:0] SDR_KIND_CIPHER = 8'h31;
  localparam logic [7:0] SDR_KIND_KEY = 8'h32;

  // ==========================================================================
  // Cipher kind codes
  localparam logic [7:0] SDR_CODE_RSVD0 = 8'h00;
  localparam logic [7:0] SDR_CODE_CABLE_VIRTUAL_CIPHER = 8'h01;
  localparam logic [7:0] SDR_CODE_AES_COUNTER_MAC_CIPHER = 8'h02;
  localparam logic [7:0] SDR_CODE_RSVD3 = 8'h03;

  // ==========================================================================
  // Container header layout
  localparam logic [4:0] SDR_HDR_OFF_COUNT = 5'h00;
  localparam logic [4:0] SDR_HDR_OFF_KIND = 5'h01;
  localparam logic [4:0] SDR_HDR_OFF_TOTAL_LO = 5'h02;
  localparam logic [4:0] SDR_HDR_OFF_TOTAL_HI = 5'h03;
  localparam logic [4:0] SDR_HDR_OFF_ENTRIES = 5'h04;
  localparam logic [7:0] SDR_HDR_LEN = 8'h05;
  localparam logic [4:0] SDR_ENT0_BASE = 5'h05;
  localparam logic [4:0] SDR_ENT1_BASE = 5'h0a;

  // ==========================================================================
  // Cipher entry layout
  localparam logic [2:0] SDR_ENT_OFF_COUNT = 3'h0;
  localparam logic [2:0] SDR_ENT_OFF_KIND = 3'h1;
  localparam logic [2:0] SDR_ENT_OFF_CODE = 3'h2;
  localparam logic [2:0] SDR_ENT_OFF_PARAM = 3'h3;
  localparam logic [2:0] SDR_ENT_OFF_SLOT = 3'h4;
  localparam logic [7:0] SDR_ENT_LEN = 8'h05;

  // ==========================================================================
  // Key descriptor layout
  localparam logic [4:0] SDR_KEY_OFF_COUNT = 5'h00;
  localparam logic [4:0] SDR_KEY_OFF_KIND = 5'h01;
  localparam logic [4:0] SDR_KEY_OFF_IDENT = 5'h02;
  localparam logic [4:0] SDR_KEY_OFF_IDENT_END = 5'h04;
  localparam logic [4:0] SDR_KEY_OFF_PAD = 5'h05;
  localparam logic [4:0] SDR_KEY_OFF_DATA = 5'h06;
  localparam logic [7:0] SDR_KEY_BYTES = 8'h10;
  localparam logic [7:0] SDR_KEY_DESC_LEN = 8'h16;
  localparam logic [7:0] SDR_PAD_VALUE = 8'h00;
  localparam logic [7:0] SDR_NUM_SLOTS = 8'h04;

  // ==========================================================================
  // Request kinds and states
  localparam logic SDR_REQ_SECURITY = 1'b0;
  localparam logic SDR_REQ_KEY = 1'b1;

  typedef enum logic [1:0] {
    SDR_ST_IDLE = 2'b00,
    SDR_ST_SEC = 2'b01,
    SDR_ST_KEY = 2'b10
  } sdr_state_e;

endpackage

// *** sdr_link_if.sv ***
`timescale 1ns/1ps
interface sdr_link_if;
  logic req_valid;
  logic req_kind;
  logic [1:0] req_slot;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;
  logic rsp_err;
  logic set_valid;
  logic [7:0] set_param;

  modport device (
    input req_valid, req_kind, req_slot, set_valid, set_param,
    output rsp_valid, rsp_data, rsp_last, rsp_err
  );

  modport host (
    output req_valid, req_kind, req_slot, set_valid, set_param,
    input rsp_valid, rsp_data, rsp_last, rsp_err
  );
endinterface

// *** sdr_cipher_entry.sv ***
`timescale 1ns/1ps
module sdr_cipher_entry
  import sdr_pkg::*;
(
  input wire logic [2:0] offs_i,
  input wire logic [7:0] code_i,
  input wire logic [7:0] param_i,
  input wire logic [7:0] slot_i,
  output logic [7:0] byte_o
);

  always_comb begin
    case (offs_i)
      SDR_ENT_OFF_COUNT: byte_o = SDR_ENT_LEN;
      SDR_ENT_OFF_KIND: byte_o = SDR_KIND_CIPHER;
      SDR_ENT_OFF_CODE: byte_o = code_i;
      SDR_ENT_OFF_PARAM: byte_o = param_i;
      SDR_ENT_OFF_SLOT: byte_o = slot_i;
      default: byte_o = 8'h00;
    endcase
  end

endmodule

// *** sdr_device_end.sv ***
`timescale 1ns/1ps
// Behaviour
// - Security request returns container contents only
// - Container never carries key descriptors
// - Header: count, kind, total size, entries
// - One cipher entry per supported mode
// - Entry: count, kind, code, param, slot
// - Slot non-zero only when usable for authentication
// - Non-zero slot names valid device auth key
// - Host picks entry by code, echoes param
// - Host never advertises its own capabilities
// - Key: count, kind, 3-byte ident, key bytes
// - Key pad byte always zero
// - Count byte equals own descriptor size
module sdr_device_end
  import sdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  sdr_link_if.device link,
  input wire logic cfg_cable_en_i,
  input wire logic [7:0] cfg_cable_param_i,
  input wire logic [7:0] cfg_cable_slot_i,
  input wire logic cfg_aes_en_i,
  input wire logic [7:0] cfg_aes_param_i,
  input wire logic [7:0] cfg_aes_slot_i,
  input wire logic key_wr_i,
  input wire logic [1:0] key_wr_slot_i,
  input wire logic key_wr_auth_i,
  input wire logic [23:0] key_wr_ident_i,
  input wire logic [127:0] key_wr_data_i,
  output logic enc_sel_valid_o,
  output logic [7:0] enc_sel_param_o,
  output logic busy_o
);

  // ==========================================================================
  // Key table
  logic [23:0] ident_r [4];
  logic [23:0] ident_nxt [4];
  logic [127:0] kdata_r [4];
  logic [127:0] kdata_nxt [4];
  logic [3:0] kvalid_r;
  logic [3:0] kvalid_nxt;
  logic [3:0] kauth_r;
  logic [3:0] kauth_nxt;

  always_comb begin
    ident_nxt = ident_r;
    kdata_nxt = kdata_r;
    kvalid_nxt = kvalid_r;
    kauth_nxt = kauth_r;
    // Slot 0 means no key, so it is never filled
    if (key_wr_i && key_wr_slot_i != 2'h0) begin
      ident_nxt[key_wr_slot_i] = key_wr_ident_i;
      kdata_nxt[key_wr_slot_i] = key_wr_data_i;
      kvalid_nxt[key_wr_slot_i] = 1'b1;
      kauth_nxt[key_wr_slot_i] = key_wr_auth_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < 4; i++) begin
        ident_r[i] <= 24'h000000;
        kdata_r[i] <= 128'h0;
      end
      kvalid_r <= 4'h0;
      kauth_r <= 4'h0;
    end else begin
      ident_r <= ident_nxt;
      kdata_r <= kdata_nxt;
      kvalid_r <= kvalid_nxt;
      kauth_r <= kauth_nxt;
    end
  end

  // Slot advertised only if it holds a valid authentication key
  function automatic logic [7:0] usable_slot(input logic [7:0] s, input logic [3:0] ok,
                                             input logic [3:0] au);
    logic [1:0] i;
    i = s[1:0];
    if (s != 8'h00 && s < SDR_NUM_SLOTS && ok[i] && au[i]) begin
      usable_slot = s;
    end else begin
      usable_slot = 8'h00;
    end
  endfunction

  // ==========================================================================
  // Response engine
  sdr_state_e state_r;
  sdr_state_e state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [1:0] kslot_r;
  logic [1:0] kslot_nxt;
  logic [1:0] nent_r;
  logic [1:0] nent_nxt;
  logic [7:0] total_r;
  logic [7:0] total_nxt;
  logic [7:0] e0_code_r;
  logic [7:0] e0_code_nxt;
  logic [7:0] e0_param_r;
  logic [7:0] e0_param_nxt;
  logic [7:0] e0_slot_r;
  logic [7:0] e0_slot_nxt;
  logic [7:0] e1_slot_r;
  logic [7:0] e1_slot_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic valid_r;
  logic valid_nxt;
  logic last_r;
  logic last_nxt;
  logic err_r;
  logic err_nxt;
  logic sel_valid_r;
  logic sel_valid_nxt;
  logic [7:0] sel_param_r;
  logic [7:0] sel_param_nxt;
  logic [7:0] ent0_byte;
  logic [7:0] ent1_byte;
  logic [7:0] sec_byte;
  logic [7:0] key_byte;
  logic [7:0] end_cnt;
  logic [23:0] sel_ident;
  logic [127:0] sel_kdata;

  sdr_cipher_entry u_ent0 (
    .offs_i(3'(cnt_r - SDR_ENT0_BASE)),
    .code_i(e0_code_r),
    .param_i(e0_param_r),
    .slot_i(e0_slot_r),
    .byte_o(ent0_byte)
  );

  // Second entry exists only when both modes are enabled, so it is always AES
  sdr_cipher_entry u_ent1 (
    .offs_i(3'(cnt_r - SDR_ENT1_BASE)),
    .code_i(SDR_CODE_AES_COUNTER_MAC_CIPHER),
    .param_i(cfg_aes_param_i),
    .slot_i(e1_slot_r),
    .byte_o(ent1_byte)
  );

  always_comb begin
    sel_ident = ident_r[kslot_r];
    sel_kdata = kdata_r[kslot_r];
    case (cnt_r)
      SDR_HDR_OFF_COUNT: sec_byte = SDR_HDR_LEN;
      SDR_HDR_OFF_KIND: sec_byte = SDR_KIND_SECURITY;
      SDR_HDR_OFF_TOTAL_LO: sec_byte = total_r;
      SDR_HDR_OFF_TOTAL_HI: sec_byte = 8'h00;
      SDR_HDR_OFF_ENTRIES: sec_byte = {6'h00, nent_r};
      default: sec_byte = (cnt_r < SDR_ENT1_BASE) ? ent0_byte : ent1_byte;
    endcase
    if (cnt_r == SDR_KEY_OFF_COUNT) begin
      key_byte = SDR_KEY_DESC_LEN;
    end else if (cnt_r == SDR_KEY_OFF_KIND) begin
      key_byte = SDR_KIND_KEY;
    end else if (cnt_r <= SDR_KEY_OFF_IDENT_END) begin
      key_byte = sel_ident[{2'(cnt_r - SDR_KEY_OFF_IDENT), 3'h0} +: 8];
    end else if (cnt_r == SDR_KEY_OFF_PAD) begin
      key_byte = SDR_PAD_VALUE;
    end else begin
      key_byte = sel_kdata[{4'(cnt_r - SDR_KEY_OFF_DATA), 3'h0} +: 8];
    end
    end_cnt = (state_r == SDR_ST_KEY) ? SDR_KEY_DESC_LEN : total_r;
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    kslot_nxt = kslot_r;
    nent_nxt = nent_r;
    total_nxt = total_r;
    e0_code_nxt = e0_code_r;
    e0_param_nxt = e0_param_r;
    e0_slot_nxt = e0_slot_r;
    e1_slot_nxt = e1_slot_r;
    data_nxt = data_r;
    valid_nxt = 1'b0;
    last_nxt = 1'b0;
    err_nxt = 1'b0;
    sel_valid_nxt = link.set_valid;
    sel_param_nxt = link.set_valid ? link.set_param : sel_param_r;
    case (state_r)
      SDR_ST_IDLE: begin
        cnt_nxt = 5'h00;
        if (link.req_valid && link.req_kind == SDR_REQ_SECURITY) begin
          state_nxt = SDR_ST_SEC;
          nent_nxt = {1'b0, cfg_cable_en_i} + {1'b0, cfg_aes_en_i};
          total_nxt = SDR_HDR_LEN + 8'(SDR_ENT_LEN * {6'h00, nent_nxt});
          e0_code_nxt = cfg_cable_en_i ? SDR_CODE_CABLE_VIRTUAL_CIPHER
                                       : SDR_CODE_AES_COUNTER_MAC_CIPHER;
          e0_param_nxt = cfg_cable_en_i ? cfg_cable_param_i : cfg_aes_param_i;
          e0_slot_nxt = usable_slot(cfg_cable_en_i ? cfg_cable_slot_i : cfg_aes_slot_i,
                                    kvalid_r, kauth_r);
          e1_slot_nxt = usable_slot(cfg_aes_slot_i, kvalid_r, kauth_r);
        end else if (link.req_valid && link.req_kind == SDR_REQ_KEY) begin
          if (kvalid_r[link.req_slot] && link.req_slot != 2'h0) begin
            state_nxt = SDR_ST_KEY;
            kslot_nxt = link.req_slot;
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      SDR_ST_SEC, SDR_ST_KEY: begin
        valid_nxt = 1'b1;
        data_nxt = (state_r == SDR_ST_KEY) ? key_byte : sec_byte;
        cnt_nxt = cnt_r + 5'h01;
        if ({3'h0, cnt_r} == end_cnt - 8'h01) begin
          last_nxt = 1'b1;
          state_nxt = SDR_ST_IDLE;
        end
      end
      default: state_nxt = SDR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= SDR_ST_IDLE;
      cnt_r <= 5'h00;
      kslot_r <= 2'h0;
      nent_r <= 2'h0;
      total_r <= SDR_HDR_LEN;
      e0_code_r <= SDR_CODE_RSVD0;
      e0_param_r <= 8'h00;
      e0_slot_r <= 8'h00;
      e1_slot_r <= 8'h00;
      data_r <= 8'h00;
      valid_r <= 1'b0;
      last_r <= 1'b0;
      err_r <= 1'b0;
      sel_valid_r <= 1'b0;
      sel_param_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      kslot_r <= kslot_nxt;
      nent_r <= nent_nxt;
      total_r <= total_nxt;
      e0_code_r <= e0_code_nxt;
      e0_param_r <= e0_param_nxt;
      e0_slot_r <= e0_slot_nxt;
      e1_slot_r <= e1_slot_nxt;
      data_r <= data_nxt;
      valid_r <= valid_nxt;
      last_r <= last_nxt;
      err_r <= err_nxt;
      sel_valid_r <= sel_valid_nxt;
      sel_param_r <= sel_param_nxt;
    end
  end

  assign link.rsp_valid = valid_r;
  assign link.rsp_data = data_r;
  assign link.rsp_last = last_r;
  assign link.rsp_err = err_r;
  assign enc_sel_valid_o = sel_valid_r;
  assign enc_sel_param_o = sel_param_r;
  assign busy_o = (state_r != SDR_ST_IDLE);

endmodule

// *** sdr_host_end.sv ***
`timescale 1ns/1ps
module sdr_host_end
  import sdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  sdr_link_if.host link,
  input wire logic get_sec_i,
  input wire logic get_key_i,
  input wire logic [1:0] key_slot_i,
  input wire logic [7:0] pref_code_i,
  output logic busy_o,
  output logic sec_done_o,
  output logic found_o,
  output logic [7:0] auth_slot_o,
  output logic [15:0] total_size_o,
  output logic [7:0] entry_count_o,
  output logic key_done_o,
  output logic key_err_o,
  output logic [23:0] key_ident_o,
  output logic [127:0] key_data_o,
  output logic fmt_err_o
);

  // ==========================================================================
  // Request, parse and selection
  sdr_state_e state_r;
  sdr_state_e state_nxt;
  logic req_r;
  logic req_nxt;
  logic kind_r;
  logic kind_nxt;
  logic [1:0] slot_r;
  logic [1:0] slot_nxt;
  logic [4:0] idx_r;
  logic [4:0] idx_nxt;
  logic [2:0] eoff_r;
  logic [2:0] eoff_nxt;
  logic [7:0] code_r;
  logic [7:0] code_nxt;
  logic [7:0] param_r;
  logic [7:0] param_nxt;
  logic found_r;
  logic found_nxt;
  logic [7:0] pick_r;
  logic [7:0] pick_nxt;
  logic [7:0] auth_r;
  logic [7:0] auth_nxt;
  logic [15:0] total_r;
  logic [15:0] total_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [23:0] ident_r;
  logic [23:0] ident_nxt;
  logic [127:0] kdata_r;
  logic [127:0] kdata_nxt;
  logic fmt_r;
  logic fmt_nxt;
  logic sdone_r;
  logic sdone_nxt;
  logic kdone_r;
  logic kdone_nxt;
  logic kerr_r;
  logic kerr_nxt;
  logic set_r;
  logic set_nxt;
  logic [7:0] d;

  always_comb begin
    d = link.rsp_data;
    state_nxt = state_r;
    req_nxt = 1'b0;
    kind_nxt = kind_r;
    slot_nxt = slot_r;
    idx_nxt = idx_r;
    eoff_nxt = eoff_r;
    code_nxt = code_r;
    param_nxt = param_r;
    found_nxt = found_r;
    pick_nxt = pick_r;
    auth_nxt = auth_r;
    total_nxt = total_r;
    count_nxt = count_r;
    ident_nxt = ident_r;
    kdata_nxt = kdata_r;
    fmt_nxt = fmt_r;
    sdone_nxt = 1'b0;
    kdone_nxt = 1'b0;
    kerr_nxt = 1'b0;
    set_nxt = 1'b0;
    case (state_r)
      SDR_ST_IDLE: begin
        idx_nxt = 5'h00;
        eoff_nxt = 3'h0;
        if (get_sec_i) begin
          state_nxt = SDR_ST_SEC;
          req_nxt = 1'b1;
          kind_nxt = SDR_REQ_SECURITY;
          found_nxt = 1'b0;
          auth_nxt = 8'h00;
          fmt_nxt = 1'b0;
        end else if (get_key_i) begin
          state_nxt = SDR_ST_KEY;
          req_nxt = 1'b1;
          kind_nxt = SDR_REQ_KEY;
          slot_nxt = key_slot_i;
          fmt_nxt = 1'b0;
        end
      end
      SDR_ST_SEC: begin
        if (link.rsp_valid) begin
          idx_nxt = idx_r + 5'h01;
          case (idx_r)
            SDR_HDR_OFF_COUNT: fmt_nxt = fmt_r | (d != SDR_HDR_LEN);
            SDR_HDR_OFF_KIND: fmt_nxt = fmt_r | (d != SDR_KIND_SECURITY);
            SDR_HDR_OFF_TOTAL_LO: total_nxt = {total_r[15:8], d};
            SDR_HDR_OFF_TOTAL_HI: total_nxt = {d, total_r[7:0]};
            SDR_HDR_OFF_ENTRIES: count_nxt = d;
            default: begin
              eoff_nxt = (eoff_r == SDR_ENT_OFF_SLOT) ? 3'h0 : eoff_r + 3'h1;
              case (eoff_r)
                SDR_ENT_OFF_COUNT: fmt_nxt = fmt_r | (d != SDR_ENT_LEN);
                SDR_ENT_OFF_KIND: fmt_nxt = fmt_r | (d != SDR_KIND_CIPHER);
                SDR_ENT_OFF_CODE: code_nxt = d;
                SDR_ENT_OFF_PARAM: param_nxt = d;
                SDR_ENT_OFF_SLOT: begin
                  // First entry with the wanted code wins; reserved codes never picked
                  if (!found_r && code_r == pref_code_i && (code_r == SDR_CODE_CABLE_VIRTUAL_CIPHER
                      || code_r == SDR_CODE_AES_COUNTER_MAC_CIPHER)) begin
                    found_nxt = 1'b1;
                    pick_nxt = param_r;
                    auth_nxt = d;
                  end
                end
                default: fmt_nxt = 1'b1;
              endcase
            end
          endcase
          if (link.rsp_last) begin
            state_nxt = SDR_ST_IDLE;
            sdone_nxt = 1'b1;
            set_nxt = found_nxt;
            fmt_nxt = fmt_nxt | (total_nxt != {11'h000, idx_nxt});
          end
        end
      end
      SDR_ST_KEY: begin
        if (link.rsp_err) begin
          state_nxt = SDR_ST_IDLE;
          kerr_nxt = 1'b1;
        end else if (link.rsp_valid) begin
          idx_nxt = idx_r + 5'h01;
          if (idx_r == SDR_KEY_OFF_COUNT) begin
            fmt_nxt = fmt_r | (d != SDR_KEY_DESC_LEN);
          end else if (idx_r == SDR_KEY_OFF_KIND) begin
            fmt_nxt = fmt_r | (d != SDR_KIND_KEY);
          end else if (idx_r <= SDR_KEY_OFF_IDENT_END) begin
            ident_nxt = {d, ident_r[23:8]};
          end else if (idx_r == SDR_KEY_OFF_PAD) begin
            fmt_nxt = fmt_r | (d != SDR_PAD_VALUE);
          end else begin
            kdata_nxt = {d, kdata_r[127:8]};
          end
          if (link.rsp_last) begin
            state_nxt = SDR_ST_IDLE;
            kdone_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = SDR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= SDR_ST_IDLE;
      req_r <= 1'b0;
      kind_r <= SDR_REQ_SECURITY;
      slot_r <= 2'h0;
      idx_r <= 5'h00;
      eoff_r <= 3'h0;
      code_r <= SDR_CODE_RSVD0;
      param_r <= 8'h00;
      found_r <= 1'b0;
      pick_r <= 8'h00;
      auth_r <= 8'h00;
      total_r <= 16'h0000;
      count_r <= 8'h00;
      ident_r <= 24'h000000;
      kdata_r <= 128'h0;
      fmt_r <= 1'b0;
      sdone_r <= 1'b0;
      kdone_r <= 1'b0;
      kerr_r <= 1'b0;
      set_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      kind_r <= kind_nxt;
      slot_r <= slot_nxt;
      idx_r <= idx_nxt;
      eoff_r <= eoff_nxt;
      code_r <= code_nxt;
      param_r <= param_nxt;
      found_r <= found_nxt;
      pick_r <= pick_nxt;
      auth_r <= auth_nxt;
      total_r <= total_nxt;
      count_r <= count_nxt;
      ident_r <= ident_nxt;
      kdata_r <= kdata_nxt;
      fmt_r <= fmt_nxt;
      sdone_r <= sdone_nxt;
      kdone_r <= kdone_nxt;
      kerr_r <= kerr_nxt;
      set_r <= set_nxt;
    end
  end

  assign link.req_valid = req_r;
  assign link.req_kind = kind_r;
  assign link.req_slot = slot_r;
  assign link.set_valid = set_r;
  assign link.set_param = pick_r;
  assign busy_o = (state_r != SDR_ST_IDLE);
  assign sec_done_o = sdone_r;
  assign found_o = found_r;
  assign auth_slot_o = auth_r;
  assign total_size_o = total_r;
  assign entry_count_o = count_r;
  assign key_done_o = kdone_r;
  assign key_err_o = kerr_r;
  assign key_ident_o = ident_r;
  assign key_data_o = kdata_r;
  assign fmt_err_o = fmt_r;

endmodule

// *** sdr_link_sva.sv ***
`timescale 1ns/1ps
module sdr_link_sva
  import sdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic req_valid,
  input wire logic req_kind,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_err
);
  logic [7:0] cnt_r, cnt_nxt, tot_r, tot_nxt;
  logic kind_r, kind_nxt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // ==========================================================================
  // Byte position and total size of the current answer
  always_comb begin
    cnt_nxt = rsp_valid ? cnt_r + 8'h01 : cnt_r;
    tot_nxt = (rsp_valid && cnt_r == 8'h02) ? rsp_data : tot_r;
    kind_nxt = req_valid ? req_kind : kind_r;
    if (req_valid) begin
      cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r <= 8'h00;
      tot_r <= 8'h00;
      kind_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tot_r <= tot_nxt;
      kind_r <= kind_nxt;
    end
  end

  // ==========================================================================
  // Properties
  property p_sec_head;
    req_valid && !req_kind |-> ##2 (rsp_valid && rsp_data == SDR_HDR_LEN)
      ##1 (rsp_valid && rsp_data == SDR_KIND_SECURITY) ##2 (rsp_valid && rsp_data == 8'h00);
  endproperty
  a_sec_head: assert property (p_sec_head) else $error("header bytes wrong");

  property p_key_head;
    req_valid && req_kind |-> ##1 (rsp_err or
      (##1 (rsp_valid && rsp_data == SDR_KEY_DESC_LEN) ##1 (rsp_data == SDR_KIND_KEY)));
  endproperty
  a_key_head: assert property (p_key_head) else $error("key answer start wrong");

  property p_pad;
    rsp_valid && kind_r && cnt_r == 8'h05 |-> rsp_data == SDR_PAD_VALUE;
  endproperty
  a_pad: assert property (p_pad) else $error("key pad byte not zero");

  property p_key_last;
    rsp_last && kind_r |-> rsp_valid && cnt_r == 8'h15;
  endproperty
  a_key_last: assert property (p_key_last) else $error("key length wrong");

  property p_sec_last;
    rsp_last && !kind_r |-> rsp_valid && cnt_r == tot_r - 8'h01;
  endproperty
  a_sec_last: assert property (p_sec_last) else $error("total size mismatch");

  property p_entry;
    rsp_valid && !kind_r && (cnt_r == 8'h05 || cnt_r == 8'h0a) |-> rsp_data == SDR_ENT_LEN
      ##1 rsp_data == SDR_KIND_CIPHER ##1 (rsp_data == 8'h01 || rsp_data == 8'h02);
  endproperty
  a_entry: assert property (p_entry) else $error("cipher entry wrong");

  property p_count;
    rsp_valid && !kind_r && cnt_r == 8'h04 |-> tot_r == rsp_data * 8'h05 + 8'h05;
  endproperty
  a_count: assert property (p_count) else $error("entry count wrong");

  property p_stream;
    rsp_valid && !rsp_last |=> rsp_valid;
  endproperty
  a_stream: assert property (p_stream) else $error("answer broken off");

  property p_err_alone;
    rsp_err |-> !rsp_valid ##1 !rsp_valid;
  endproperty
  a_err_alone: assert property (p_err_alone) else $error("refusal carries data");

  c_sec: cover property (rsp_last && !kind_r && cnt_r == 8'h0e);
  c_key: cover property (rsp_last && kind_r);
  c_err: cover property (rsp_err);
endmodule

// *** sdr_bench.sv ***
`timescale 1ns/1ps
module sdr_bench;
  import sdr_pkg::*;
  localparam logic [127:0] k1 = 128'h0f0e0d0c0b0a09080706050403020100;
  localparam logic [127:0] k2 = 128'h8899aabbccddeeff0011223344556677;
  logic clk_i = 1'b0, srst_i = 1'b1, cab_en = 1'b0, aes_en = 1'b0, kw = 1'b0, kw_auth = 1'b0;
  logic get_sec = 1'b0, get_key = 1'b0, get_key2 = 1'b0;
  logic [7:0] cab_par = 8'h11, aes_par = 8'h22, cab_slot = 8'h01, aes_slot = 8'h02;
  logic [7:0] pref = 8'h01;
  logic [1:0] kw_slot = 2'h0, kslot = 2'h1;
  logic [23:0] kw_id = 24'h000000, kid;
  logic [127:0] kw_data = 128'h0, kdata;
  logic enc_v, sec_done, found, kdone, kerr, ferr, ferr2, dbusy, hbusy;
  logic [7:0] enc_p, aslot, ecount;
  logic [15:0] tot;
  logic [7:0] rx[$];
  int bad_count = 0;
  int checks_done = 0;

  sdr_link_if link();
  sdr_link_if link2();

  sdr_device_end sdr_device_end_inst (.clk_i(clk_i), .srst_i(srst_i), .link(link),
    .cfg_cable_en_i(cab_en), .cfg_cable_param_i(cab_par), .cfg_cable_slot_i(cab_slot),
    .cfg_aes_en_i(aes_en), .cfg_aes_param_i(aes_par), .cfg_aes_slot_i(aes_slot),
    .key_wr_i(kw), .key_wr_slot_i(kw_slot), .key_wr_auth_i(kw_auth), .key_wr_ident_i(kw_id),
    .key_wr_data_i(kw_data), .enc_sel_valid_o(enc_v), .enc_sel_param_o(enc_p), .busy_o(dbusy));

  sdr_host_end sdr_host_end_inst (.clk_i(clk_i), .srst_i(srst_i), .link(link),
    .get_sec_i(get_sec), .get_key_i(get_key), .key_slot_i(kslot), .pref_code_i(pref),
    .busy_o(hbusy), .sec_done_o(sec_done), .found_o(found), .auth_slot_o(aslot),
    .total_size_o(tot), .entry_count_o(ecount), .key_done_o(kdone), .key_err_o(kerr),
    .key_ident_o(kid), .key_data_o(kdata), .fmt_err_o(ferr));

  // ==========================================================================
  // Host facing a faulty far end driven by the bench
  sdr_host_end sdr_host_end_inst_b (.clk_i(clk_i), .srst_i(srst_i), .link(link2),
    .get_sec_i(1'b0), .get_key_i(get_key2), .key_slot_i(kslot), .pref_code_i(pref),
    .busy_o(), .sec_done_o(), .found_o(), .auth_slot_o(), .total_size_o(),
    .entry_count_o(), .key_done_o(), .key_err_o(), .key_ident_o(), .key_data_o(),
    .fmt_err_o(ferr2));

  sdr_link_sva sdr_link_sva_inst (.clk_i(clk_i), .srst_i(srst_i), .req_valid(link.req_valid),
    .req_kind(link.req_kind), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
    .rsp_last(link.rsp_last), .rsp_err(link.rsp_err));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (link.rsp_valid === 1'b1) rx.push_back(link.rsp_data);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks_done++;
    if (e !== g) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_done();
    int n;
    for (n = 0; n < 200 && (sec_done | kdone | kerr) !== 1'b1; n++) @(negedge clk_i);
    if (n == 200) begin
      chk("done_wait", 1'b1, 1'b0);
      complete_run();
    end
  endtask

  task automatic t_wr(input logic [1:0] s, input logic au, input logic [23:0] id,
                      input logic [127:0] d);
    @(posedge clk_i);
    kw <= 1'b1;
    kw_slot <= s;
    kw_auth <= au;
    kw_id <= id;
    kw_data <= d;
    @(posedge clk_i);
    kw <= 1'b0;
  endtask

  task automatic t_sec(input logic c, input logic a, input logic [7:0] p, input logic fd,
                       input logic [7:0] sl);
    logic [7:0] len;
    len = 8'h05 + 8'h05 * ({7'h00, c} + {7'h00, a});
    @(posedge clk_i);
    cab_en <= c;
    aes_en <= a;
    pref <= p;
    get_sec <= 1'b1;
    rx.delete();
    @(posedge clk_i);
    get_sec <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("dev_busy", 1'b1, dbusy);
    chk("host_busy", 1'b1, hbusy);
    chk("req_kind", SDR_REQ_SECURITY, link.req_kind);
    wait_done();
    chk("total", len, tot);
    chk("count", {7'h00, c} + {7'h00, a}, ecount);
    chk("found", fd, found);
    chk("auth_slot", sl, aslot);
    chk("fmt_err", 1'b0, ferr);
    chk("wire_len", len, rx.size());
    chk("wire_total_lo", len, rx[2]);
    chk("wire_total_hi", 8'h00, rx[3]);
    @(negedge clk_i);
    chk("enc_sel", fd, enc_v);
    if (fd)
      chk("enc_param", (p == 8'h01) ? cab_par : aes_par, enc_p);
  endtask

  task automatic t_key(input logic [1:0] s, input logic er, input logic [23:0] id,
                       input logic [127:0] d);
    @(posedge clk_i);
    kslot <= s;
    get_key <= 1'b1;
    rx.delete();
    @(posedge clk_i);
    get_key <= 1'b0;
    wait_done();
    chk("key_err", er, kerr);
    if (!er) begin
      chk("key_ident", id, kid);
      chk("key_data", d, kdata);
      chk("wire_key_len", SDR_KEY_DESC_LEN, rx.size());
      chk("wire_ident_lo", id[7:0], rx[2]);
      chk("wire_pad", 8'h00, rx[5]);
    end
  endtask

  task automatic t_bad_pad();
    int i;
    @(posedge clk_i);
    get_key2 <= 1'b1;
    @(posedge clk_i);
    get_key2 <= 1'b0;
    for (i = 0; i < 20 && link2.req_valid !== 1'b1; i++) @(negedge clk_i);
    if (i == 20) begin
      chk("bad_pad_req", 1'b1, 1'b0);
      complete_run();
    end
    @(posedge clk_i);
    for (i = 0; i < 22; i++) begin
      @(posedge clk_i);
      link2.rsp_valid <= 1'b1;
      link2.rsp_data <= (i == 0) ? 8'h16 : (i == 1) ? SDR_KIND_KEY : (i == 5) ? 8'h5a : i[7:0];
      link2.rsp_last <= (i == 21);
    end
    @(posedge clk_i);
    link2.rsp_valid <= 1'b0;
    link2.rsp_last <= 1'b0;
    link2.rsp_data <= ~link2.rsp_data;
    repeat (4) @(negedge clk_i);
    chk("bad_pad_fmt", 1'b1, ferr2);
  endtask

  initial begin
    link2.rsp_valid = 1'b0;
    link2.rsp_last = 1'b0;
    link2.rsp_err = 1'b0;
    link2.rsp_data = 8'h00;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    t_wr(2'h1, 1'b1, 24'h123456, k1);
    t_wr(2'h2, 1'b0, 24'habcdef, k2);
    t_sec(1'b1, 1'b1, 8'h01, 1'b1, 8'h01);
    t_sec(1'b1, 1'b1, 8'h02, 1'b1, 8'h00);
    t_sec(1'b0, 1'b1, 8'h01, 1'b0, 8'h00);
    t_sec(1'b1, 1'b0, 8'h01, 1'b1, 8'h01);
    t_sec(1'b0, 1'b0, 8'h02, 1'b0, 8'h00);
    t_sec(1'b1, 1'b1, 8'h00, 1'b0, 8'h00);
    t_sec(1'b1, 1'b1, 8'h03, 1'b0, 8'h00);
    t_key(2'h1, 1'b0, 24'h123456, k1);
    t_key(2'h2, 1'b0, 24'habcdef, k2);
    t_key(2'h0, 1'b1, 24'h0, 128'h0);
    t_key(2'h3, 1'b1, 24'h0, 128'h0);
    t_bad_pad();
    complete_run();
  end
endmodule
